/* File: hw/clk_gate_pkg.sv */
package clk_gate_pkg;

    // ------------------------------------------------------------
    // register offsets (byte addresses on the 12-bit apb window)
    // ------------------------------------------------------------
    localparam logic [11:0] RUN_MODE_CLOCK_CONFIG_OFF = 12'h000;
    localparam logic [11:0] RUN_CLOCK_GATING_1_OFF = 12'h100;
    localparam logic [11:0] SLEEP_CLOCK_GATING_1_OFF = 12'h110;
    localparam logic [11:0] DEEP_SLEEP_CLOCK_GATING_1_OFF = 12'h124;
    localparam logic [11:0] GATE_STATUS_OFF = 12'h130;
    localparam logic [11:0] POWER_MODE_STATUS_OFF = 12'h134;

    // ------------------------------------------------------------
    // field positions and reset values
    // ------------------------------------------------------------
    localparam int COMPARATOR2_CLOCK_GATE_BIT = 26;
    localparam int COMPARATOR1_CLOCK_GATE_BIT = 25;
    localparam int COMPARATOR0_CLOCK_GATE_BIT = 24;
    localparam int GP_TMR2_BIT = 18;
    localparam int GP_TMR1_BIT = 17;
    localparam int GP_TMR0_BIT = 16;
    localparam int TWO_WIRE_BIT = 12;
    localparam int SYNC_SERIAL_BIT = 4;
    localparam int ASYNC_SERIAL1_BIT = 1;
    localparam int ASYNC_SERIAL0_BIT = 0;
    localparam int AUTO_CLOCK_GATING_BIT = 0;
    localparam logic [31:0] GATE_WRITE_MASK = 32'h0707_1013;
    localparam logic [31:0] GATE_RESET = 32'h0000_0000;
    localparam logic [31:0] CONFIG_RESET = 32'h0000_0000;
    localparam int NUM_UNITS = 10;

    // ------------------------------------------------------------
    // power modes, gray coded along run -> sleep -> deep sleep
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        MODE_RUN = 2'b00,
        MODE_SLEEP = 2'b01,
        MODE_DEEP = 2'b11
    } power_mode_e;

    // register layout to unit vector, unit 0 = async serial 0
    function automatic logic [NUM_UNITS-1:0] to_units(input logic [31:0] r);
        to_units = {r[COMPARATOR2_CLOCK_GATE_BIT], r[COMPARATOR1_CLOCK_GATE_BIT], r[COMPARATOR0_CLOCK_GATE_BIT],
                    r[GP_TMR2_BIT], r[GP_TMR1_BIT], r[GP_TMR0_BIT],
                    r[TWO_WIRE_BIT], r[SYNC_SERIAL_BIT],
                    r[ASYNC_SERIAL1_BIT], r[ASYNC_SERIAL0_BIT]};
    endfunction

    // unit vector back to register layout, reserved bits zero
    function automatic logic [31:0] from_units(input logic [NUM_UNITS-1:0] u);
        from_units = 32'h0000_0000;
        from_units[COMPARATOR2_CLOCK_GATE_BIT] = u[9];
        from_units[COMPARATOR1_CLOCK_GATE_BIT] = u[8];
        from_units[COMPARATOR0_CLOCK_GATE_BIT] = u[7];
        from_units[GP_TMR2_BIT] = u[6];
        from_units[GP_TMR1_BIT] = u[5];
        from_units[GP_TMR0_BIT] = u[4];
        from_units[TWO_WIRE_BIT] = u[3];
        from_units[SYNC_SERIAL_BIT] = u[2];
        from_units[ASYNC_SERIAL1_BIT] = u[1];
        from_units[ASYNC_SERIAL0_BIT] = u[0];
    endfunction

endpackage

/* File: hw/unit_clock_cell.sv */
`timescale 1ns/10ps
// ------------------------------------------------------------
// latch based clock gate for one unit
// ------------------------------------------------------------
module unit_clock_cell (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // gate enable, from a flip-flop
    input wire logic en,
    // gated clock
    output logic gclk
);

    logic en_l;

    // enable only moves while the clock is low, so no pulse is cut short
    always_latch begin
        if (!rst_n) begin
            en_l = 1'b0;
        end else if (!clk) begin
            en_l = en;
        end
    end

    assign gclk = clk & en_l;

endmodule // unit_clock_cell

/* File: hw/unit_access_guard.sv */
`timescale 1ns/10ps
// ------------------------------------------------------------
// grants unit accesses, faults those aimed at unclocked units
// ------------------------------------------------------------
module unit_access_guard (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // access from the bus fabric
    input wire logic req,
    input wire logic [clk_gate_pkg::NUM_UNITS-1:0] sel,
    input wire logic [clk_gate_pkg::NUM_UNITS-1:0] en,
    // answer
    output logic grant_r,
    output logic fault_r
);

    logic grant_nxt;
    logic fault_nxt;
    logic blocked;

    // any selected unit without clock blocks the whole access
    always_comb begin
        blocked = |(sel & ~en);
        grant_nxt = req && (sel != '0) && !blocked;
        fault_nxt = req && blocked;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            grant_r <= 1'b0;
            fault_r <= 1'b0;
        end else begin
            grant_r <= grant_nxt;
            fault_r <= fault_nxt;
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    fault_on_gated_a: assert property (
        (req && |(sel & ~en)) |=> (fault_r && !grant_r))
        else $error("access to unclocked unit not faulted");

    fault_has_cause_a: assert property (
        fault_r |-> $past(req) && |($past(sel) & ~$past(en)))
        else $error("fault raised without gated access");

endmodule // unit_access_guard

/* File: hw/deep_sleep_clock_gate_reg1.sv */
// Local design decision: register access over APB.
`timescale 1ns/10ps
module deep_sleep_clock_gate_reg1 (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic pready,
    output logic [31:0] prdata,
    output logic pslverr,
    // power mode requests from the core
    input wire logic sleep_req,
    input wire logic deep_sleep_req,
    // unit access check
    input wire logic unit_req,
    input wire logic [clk_gate_pkg::NUM_UNITS-1:0] unit_sel,
    output logic unit_grant,
    output logic unit_fault,
    // gated unit clocks
    output logic [clk_gate_pkg::NUM_UNITS-1:0] unit_clk
);

    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    logic [31:0] run_r;
    logic [31:0] run_nxt;
    logic [31:0] sleep_r;
    logic [31:0] sleep_nxt;
    logic [31:0] deep_r;
    logic [31:0] deep_nxt;
    logic [31:0] config_r;
    logic [31:0] config_nxt;
    logic [31:0] prdata_r;
    logic [31:0] prdata_nxt;
    logic pslverr_r;
    logic pslverr_nxt;
    clk_gate_pkg::power_mode_e mode_r;
    clk_gate_pkg::power_mode_e mode_nxt;
    logic [clk_gate_pkg::NUM_UNITS-1:0] eff_en_r;
    logic [clk_gate_pkg::NUM_UNITS-1:0] eff_en_nxt;
    logic setup;
    logic access;
    logic wr_ok;
    logic auto_clock_gating_enable;

    // ------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------

    // true for any mapped, word aligned offset
    function automatic logic addr_hit(input logic [11:0] a);
        case (a)
            clk_gate_pkg::RUN_MODE_CLOCK_CONFIG_OFF,
            clk_gate_pkg::RUN_CLOCK_GATING_1_OFF,
            clk_gate_pkg::SLEEP_CLOCK_GATING_1_OFF,
            clk_gate_pkg::DEEP_SLEEP_CLOCK_GATING_1_OFF,
            clk_gate_pkg::GATE_STATUS_OFF,
            clk_gate_pkg::POWER_MODE_STATUS_OFF: addr_hit = 1'b1;
            default: addr_hit = 1'b0;
        endcase
    endfunction

    // true for the three gating registers only
    function automatic logic is_gate(input logic [11:0] a);
        is_gate = (a == clk_gate_pkg::RUN_CLOCK_GATING_1_OFF) ||
                  (a == clk_gate_pkg::SLEEP_CLOCK_GATING_1_OFF) ||
                  (a == clk_gate_pkg::DEEP_SLEEP_CLOCK_GATING_1_OFF);
    endfunction

    // bus phases; the answer never waits, data is staged at setup
    assign setup = psel && !penable;
    assign access = psel && penable;
    assign wr_ok = access && pwrite && addr_hit(paddr);
    assign auto_clock_gating_enable = config_r[clk_gate_pkg::AUTO_CLOCK_GATING_BIT];

    // ------------------------------------------------------------
    // apb read path
    // ------------------------------------------------------------

    // read data and error are registered in the setup cycle
    always_comb begin
        prdata_nxt = prdata_r;
        pslverr_nxt = pslverr_r;
        if (setup) begin
            pslverr_nxt = !addr_hit(paddr);
            case (paddr)
                clk_gate_pkg::RUN_MODE_CLOCK_CONFIG_OFF: begin
                    prdata_nxt = config_r;
                end
                clk_gate_pkg::RUN_CLOCK_GATING_1_OFF: begin
                    prdata_nxt = run_r;
                end
                clk_gate_pkg::SLEEP_CLOCK_GATING_1_OFF: begin
                    prdata_nxt = sleep_r;
                end
                clk_gate_pkg::DEEP_SLEEP_CLOCK_GATING_1_OFF: begin
                    prdata_nxt = deep_r;
                end
                clk_gate_pkg::GATE_STATUS_OFF: begin
                    prdata_nxt = clk_gate_pkg::from_units(eff_en_r);
                end
                clk_gate_pkg::POWER_MODE_STATUS_OFF: begin
                    prdata_nxt = {30'h0000_0000, mode_r};
                end
                default: begin
                    prdata_nxt = 32'h0000_0000;
                end
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_r <= 32'h0000_0000;
            pslverr_r <= 1'b0;
        end else begin
            prdata_r <= prdata_nxt;
            pslverr_r <= pslverr_nxt;
        end
    end

    assign pready = access;
    assign prdata = prdata_r;
    assign pslverr = pslverr_r && access;

    // ------------------------------------------------------------
    // apb write path and register file
    // ------------------------------------------------------------

    // reserved bits are masked off, so they always read back zero
    always_comb begin
        run_nxt = run_r;
        sleep_nxt = sleep_r;
        deep_nxt = deep_r;
        config_nxt = config_r;
        if (wr_ok) begin
            case (paddr)
                clk_gate_pkg::RUN_CLOCK_GATING_1_OFF: begin
                    run_nxt = pwdata & clk_gate_pkg::GATE_WRITE_MASK;
                end
                clk_gate_pkg::SLEEP_CLOCK_GATING_1_OFF: begin
                    sleep_nxt = pwdata & clk_gate_pkg::GATE_WRITE_MASK;
                end
                clk_gate_pkg::DEEP_SLEEP_CLOCK_GATING_1_OFF: begin
                    deep_nxt = pwdata & clk_gate_pkg::GATE_WRITE_MASK;
                end
                clk_gate_pkg::RUN_MODE_CLOCK_CONFIG_OFF: begin
                    config_nxt = 32'h0000_0000;
                    config_nxt[clk_gate_pkg::AUTO_CLOCK_GATING_BIT] =
                        pwdata[clk_gate_pkg::AUTO_CLOCK_GATING_BIT];
                end
                default: begin
                    config_nxt = config_r; // status offsets are read only
                end
            endcase
        end
    end

    // every unit starts unclocked until software enables it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            run_r <= clk_gate_pkg::GATE_RESET;
            sleep_r <= clk_gate_pkg::GATE_RESET;
            deep_r <= clk_gate_pkg::GATE_RESET;
            config_r <= clk_gate_pkg::CONFIG_RESET;
        end else begin
            run_r <= run_nxt;
            sleep_r <= sleep_nxt;
            deep_r <= deep_nxt;
            config_r <= config_nxt;
        end
    end

    // ------------------------------------------------------------
    // power mode tracking
    // ------------------------------------------------------------

    // deep sleep request outranks plain sleep
    always_comb begin
        mode_nxt = mode_r;
        case (mode_r)
            clk_gate_pkg::MODE_RUN: begin
                if (deep_sleep_req) begin
                    mode_nxt = clk_gate_pkg::MODE_DEEP;
                end else if (sleep_req) begin
                    mode_nxt = clk_gate_pkg::MODE_SLEEP;
                end
            end
            clk_gate_pkg::MODE_SLEEP: begin
                if (deep_sleep_req) begin
                    mode_nxt = clk_gate_pkg::MODE_DEEP;
                end else if (!sleep_req) begin
                    mode_nxt = clk_gate_pkg::MODE_RUN;
                end
            end
            clk_gate_pkg::MODE_DEEP: begin
                if (!deep_sleep_req) begin
                    mode_nxt = sleep_req ? clk_gate_pkg::MODE_SLEEP
                                         : clk_gate_pkg::MODE_RUN;
                end
            end
            default: begin
                mode_nxt = clk_gate_pkg::MODE_RUN;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_r <= clk_gate_pkg::MODE_RUN;
        end else begin
            mode_r <= mode_nxt;
        end
    end

    // ------------------------------------------------------------
    // effective enables
    // ------------------------------------------------------------

    // registered so the gate cells see a clean, glitch-free level
    always_comb begin
        eff_en_nxt = clk_gate_pkg::to_units(run_r);
        if (auto_clock_gating_enable) begin
            case (mode_r)
                clk_gate_pkg::MODE_SLEEP: begin
                    eff_en_nxt = clk_gate_pkg::to_units(sleep_r);
                end
                clk_gate_pkg::MODE_DEEP: begin
                    eff_en_nxt = clk_gate_pkg::to_units(deep_r);
                end
                default: begin
                    eff_en_nxt = clk_gate_pkg::to_units(run_r);
                end
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            eff_en_r <= '0;
        end else begin
            eff_en_r <= eff_en_nxt;
        end
    end

    // ------------------------------------------------------------
    // unit clocks and access guard
    // ------------------------------------------------------------

    // one gate cell per unit; unit bits follow the unit vector order, unit 0 = async serial 0
    for (genvar i = 0; i < clk_gate_pkg::NUM_UNITS; i++) begin : g_cell
        unit_clock_cell u_cell (
            .clk(pclk),
            .rst_n(presetn),
            .en(eff_en_r[i]),
            .gclk(unit_clk[i])
        );
    end

    // faults use the same registered enables the clocks use
    unit_access_guard u_guard (
        .pclk(pclk),
        .presetn(presetn),
        .req(unit_req),
        .sel(unit_sel),
        .en(eff_en_r),
        .grant_r(unit_grant),
        .fault_r(unit_fault)
    );

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence deep_write_s;
        psel && penable && pwrite &&
            (paddr == clk_gate_pkg::DEEP_SLEEP_CLOCK_GATING_1_OFF);
    endsequence

    sequence gate_read_s;
        (psel && !penable && !pwrite && is_gate(paddr)) ##1 (psel && penable);
    endsequence

    reset_all_zero_a: assert property (
        !$past(presetn) |-> (deep_r == 32'h0000_0000) && (eff_en_r == '0))
        else $error("gating state not zero after reset");

    deep_mode_select_a: assert property (
        (auto_clock_gating_enable && mode_r == clk_gate_pkg::MODE_DEEP) |=>
            eff_en_r == clk_gate_pkg::to_units($past(deep_r)))
        else $error("deep sleep gating not applied");

    no_auto_run_a: assert property (
        !auto_clock_gating_enable |=> eff_en_r == clk_gate_pkg::to_units($past(run_r)))
        else $error("run gating not applied without auto gating");

    comparator_bits_a: assert property (
        deep_write_s |=> deep_r[26:24] == $past(pwdata[26:24]))
        else $error("comparator gate bits not written");

    timer_bits_a: assert property (
        deep_write_s |=> deep_r[18:16] == $past(pwdata[18:16]))
        else $error("timer gate bits not written");

    serial_bits_a: assert property (
        deep_write_s |=> {deep_r[12], deep_r[4], deep_r[1:0]} ==
            {$past(pwdata[12]), $past(pwdata[4]), $past(pwdata[1:0])})
        else $error("serial gate bits not written");

    reserved_zero_a: assert property (
        gate_read_s |-> (prdata & ~clk_gate_pkg::GATE_WRITE_MASK) == 32'h0000_0000)
        else $error("reserved bits read nonzero");

    // the guard answers from the enables that clock the units this cycle
    unit_clock_off_a: assert property (
        (!eff_en_r[0] && unit_req && unit_sel[0]) |=> unit_fault)
        else $error("unclocked unit access not faulted");

    reserved_write_a: assert property (
        deep_write_s |=> (deep_r & ~clk_gate_pkg::GATE_WRITE_MASK) == 32'h0000_0000)
        else $error("reserved gate bits stored on write");

endmodule // deep_sleep_clock_gate_reg1

/* File: bench/tb.sv */
`timescale 1ns/10ps
module tb;
    // ------------------------------------------------------------
    // signals and bookkeeping
    // ------------------------------------------------------------
    logic pclk, presetn, psel, penable, pwrite, sleep_req, deep_sleep_req, unit_req;
    logic pready, pslverr, unit_grant, unit_fault;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [9:0] unit_sel, unit_clk;
    int n_errors = 0;
    int checks_done = 0;
    // register bit of each unit, unit 0 = async serial 0
    localparam int ubit [10] = '{0, 1, 4, 12, 16, 17, 18, 24, 25, 26};
    localparam logic [31:0] wmask = 32'h0707_1013;

    deep_sleep_clock_gate_reg1 DUT (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
        .prdata(prdata), .pslverr(pslverr), .sleep_req(sleep_req),
        .deep_sleep_req(deep_sleep_req), .unit_req(unit_req), .unit_sel(unit_sel),
        .unit_grant(unit_grant), .unit_fault(unit_fault), .unit_clk(unit_clk)
    );

    // free running bus clock, 200 MHz
    initial begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end

    // ------------------------------------------------------------
    // checking and bus tasks
    // ------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // one apb transfer; the answer is taken at the edge where pready is seen high
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] rd, output logic err);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        forever begin
            @(posedge pclk);
            if (pready === 1'b1) break;
            n++;
            if (n > 50) begin
                n_errors++;
                give_verdict();
            end
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic exp_err);
        logic [31:0] rd;
        logic err;
        apb(1'b1, a, d, rd, err);
        chk({31'h0, err}, {31'h0, exp_err});
    endtask

    task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp, input logic exp_err);
        logic [31:0] rd;
        logic err;
        apb(1'b0, a, 32'h0000_0000, rd, err);
        chk(rd, exp);
        chk({31'h0, err}, {31'h0, exp_err});
    endtask

    // one access cycle; the answer must come on the following cycle
    task automatic unit_try(input logic [9:0] s, input logic [9:0] en);
        @(posedge pclk);
        unit_req <= 1'b1;
        unit_sel <= s;
        @(posedge pclk);
        unit_req <= 1'b0;
        #1;
        chk({30'h0, unit_grant, unit_fault},
            {30'h0, s != 10'h000 && (s & ~en) == 10'h000, (s & ~en) != 10'h000});
    endtask

    // enabled units see the high phase, gated ones stay low
    task automatic clk_chk(input logic [9:0] en);
        @(posedge pclk);
        #1;
        chk({22'h0, unit_clk}, {22'h0, en});
        @(negedge pclk);
        #1;
        chk({22'h0, unit_clk}, 32'h0000_0000);
    endtask

    // effective gating in register layout
    function automatic logic [31:0] eff(input logic auto_clock_gating_enable, input logic [1:0] m,
                                        input logic [31:0] r, s, d);
        if (!auto_clock_gating_enable || m == 2'b00) return r & wmask;
        if (m == 2'b01) return s & wmask;
        return d & wmask;
    endfunction

    function automatic logic [9:0] units(input logic [31:0] v);
        for (int i = 0; i < 10; i++) units[i] = v[ubit[i]];
    endfunction

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        logic [31:0] r, s, d, c, e;
        logic auto_clock_gating_enable;
        logic [1:0] m, mc;
        {psel, penable, pwrite, sleep_req, deep_sleep_req, unit_req} = 6'h00;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
        unit_sel = 10'h000;
        presetn = 1'b0;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        void'($urandom(69855));
        // reset state, plus unmapped and unaligned places
        // offset zero is the config word, the next five words are unmapped
        foreach (ubit[i]) if (i < 6) rd_chk(12'h000 + 12'(i) * 12'h004, 32'h0, 1'(i != 0));
        rd_chk(12'h100, 32'h0, 1'b0);
        rd_chk(12'h110, 32'h0, 1'b0);
        rd_chk(12'h124, 32'h0, 1'b0);
        rd_chk(12'h130, 32'h0, 1'b0);
        rd_chk(12'h125, 32'h0, 1'b1);
        unit_try(10'h001, 10'h000);
        $display("test reset values done");
        // random gating settings in every mode
        for (int k = 0; k < 14; k++) begin
            r = (k == 0) ? 32'hffff_ffff : $urandom;
            s = (k == 1) ? 32'h0000_0000 : $urandom;
            d = (k == 0) ? 32'hffff_ffff : $urandom;
            auto_clock_gating_enable = (k < 6) ? 1'(k > 2) : 1'($urandom);
            m = (k < 6) ? 2'(k % 3) : 2'($urandom % 3);
            mc = (m == 2'd2) ? 2'b11 : m;
            @(posedge pclk);
            sleep_req <= (m == 2'd1) || (m == 2'd2 && 1'($urandom));
            deep_sleep_req <= (m == 2'd2);
            c = $urandom;
            wr(12'h000, {c[31:1], auto_clock_gating_enable}, 1'b0);
            wr(12'h100, r, 1'b0);
            wr(12'h110, s, 1'b0);
            wr(12'h124, d, 1'b0);
            wr(12'h130, $urandom, 1'b0);
            wr(12'h3fc, $urandom, 1'b1);
            repeat (4) @(posedge pclk);
            e = eff(auto_clock_gating_enable, m, r, s, d);
            rd_chk(12'h000, {31'h0, auto_clock_gating_enable}, 1'b0);
            rd_chk(12'h100, r & wmask, 1'b0);
            rd_chk(12'h110, s & wmask, 1'b0);
            rd_chk(12'h124, d & wmask, 1'b0);
            rd_chk(12'h130, e, 1'b0);
            rd_chk(12'h134, {30'h0, mc}, 1'b0);
            for (int i = 0; i < 10; i++) unit_try(10'h001 << i, units(e));
            unit_try(10'($urandom), units(e));
            unit_try(10'h000, units(e));
            clk_chk(units(e));
        end
        $display("test random gating done");
        // second reset in mid-run clears everything
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        sleep_req <= 1'b0;
        deep_sleep_req <= 1'b0;
        rd_chk(12'h124, 32'h0, 1'b0);
        rd_chk(12'h100, 32'h0, 1'b0);
        rd_chk(12'h000, 32'h0, 1'b0);
        clk_chk(10'h000);
        unit_try(10'h3ff, 10'h000);
        $display("test mid-run reset done");
        give_verdict();
    end
endmodule // tb
